// ---- rtl/tpc_timer.sv ----
// Two-phase event counter and retriggerable one-shot timer
`timescale 1ns/100ps
`default_nettype none

module tpc_timer #(
    parameter int CNT_W = 16
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire tpc_pkg::tpc_bus_req_t bus_req,
    output logic [tpc_pkg::DATA_W-1:0] bus_rdata,
    input wire logic phase_a_trigger_pin,
    input wire logic phase_b_pulse_pin_i,
    output logic phase_b_pulse_pin_o,
    output logic phase_b_pulse_pin_oe,
    input wire logic other_timer_ovf,
    input wire logic sub_clk,
    output logic irq
);
    import tpc_pkg::*;

    generate
        if (CNT_W < 2 || CNT_W > DATA_W) begin : g_bad_width
            $error("CNT_W must lie between 2 and DATA_W");
        end
    endgenerate

    typedef enum logic {
        OS_IDLE,
        OS_RUN
    } tpc_os_state_t;

    function automatic logic [DATA_W-1:0] to_data(logic [CNT_W-1:0] v);
        return DATA_W'(v);
    endfunction

    tpc_ctrl_t ctrl_reg;
    tpc_os_state_t os_state_reg, os_state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] reload_reg;
    logic [STAT_W-1:0] stat_reg, stat_next;
    logic [STAT_W-1:0] mask_reg;
    logic [PRESC_W-1:0] presc_reg;
    logic [PRESC_W-1:0] sub_div_reg;
    logic a_s1_reg, a_s2_reg, a_d_reg;
    logic b_s1_reg, b_s2_reg, b_d_reg;
    logic sub_s1_reg, sub_s2_reg, sub_d_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic irq_reg;
    logic pin_o_reg, pin_oe_reg;

    logic wr_timer, wr_ctrl, wr_status, wr_mask;
    logic a_rise, a_fall, a_chg, b_chg, sub_rise;
    logic tp_active, step, up, tp_step, tp_wrap;
    logic tick, os_trig, os_done, os_load, os_dec, counting, cnt_le1;

    // Register decode
    always_comb begin
        wr_timer = bus_req.wr && bus_req.addr == TIMER_OFS;
        wr_ctrl = bus_req.wr && bus_req.addr == CTRL_OFS;
        wr_status = bus_req.wr && bus_req.addr == STATUS_OFS;
        wr_mask = bus_req.wr && bus_req.addr == MASK_OFS;
    end

    // Pin synchronisers
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            a_s1_reg <= 1'b0;
            a_s2_reg <= 1'b0;
            a_d_reg <= 1'b0;
            b_s1_reg <= 1'b0;
            b_s2_reg <= 1'b0;
            b_d_reg <= 1'b0;
            sub_s1_reg <= 1'b0;
            sub_s2_reg <= 1'b0;
            sub_d_reg <= 1'b0;
        end else begin
            a_s1_reg <= phase_a_trigger_pin;
            a_s2_reg <= a_s1_reg;
            a_d_reg <= a_s2_reg;
            b_s1_reg <= phase_b_pulse_pin_i;
            b_s2_reg <= b_s1_reg;
            b_d_reg <= b_s2_reg;
            sub_s1_reg <= sub_clk;
            sub_s2_reg <= sub_s1_reg;
            sub_d_reg <= sub_s2_reg;
        end
    end

    // Edge and phase decode
    always_comb begin
        a_rise = a_s2_reg & ~a_d_reg;
        a_fall = ~a_s2_reg & a_d_reg;
        a_chg = a_s2_reg ^ a_d_reg;
        b_chg = b_s2_reg ^ b_d_reg;
        sub_rise = sub_s2_reg & ~sub_d_reg;
        tp_active = ctrl_reg.start & ~ctrl_reg.one_shot;
        if (ctrl_reg.x4) begin
            step = a_chg ^ b_chg;
            up = a_d_reg ^ b_s2_reg;
        end else begin
            step = b_s2_reg & (a_rise | a_fall);
            up = a_rise;
        end
        tp_step = tp_active & step;
        tp_wrap = tp_step & (up ? &cnt_reg : ~|cnt_reg);
    end

    // Prescaler and count source select
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            presc_reg <= '0;
        end else begin
            presc_reg <= presc_reg + 1'b1;
        end
    end
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sub_div_reg <= '0;
        end else if (sub_rise) begin
            sub_div_reg <= sub_div_reg + 1'b1;
        end
    end
    always_comb begin
        case (ctrl_reg.csel)
            CSEL_DIV1: tick = 1'b1;
            CSEL_DIV8: tick = presc_reg[2:0] == DIV8_LAST;
            CSEL_DIV32: tick = presc_reg == DIV32_LAST;
            CSEL_SUB32: tick = sub_rise && sub_div_reg == DIV32_LAST;
            default: tick = 1'b0;
        endcase
    end

    // One-shot trigger and sequencing
    always_comb begin
        os_trig = 1'b0;
        if (ctrl_reg.one_shot && ctrl_reg.start) begin
            case (ctrl_reg.tsel)
                TSEL_PIN: os_trig = a_rise;
                TSEL_TIMER: os_trig = other_timer_ovf;
                default: os_trig = 1'b0;
            endcase
            if (wr_ctrl && bus_req.wdata[1]) begin
                os_trig = 1'b1;
            end
        end
        cnt_le1 = ~|cnt_reg[CNT_W-1:1];
        os_done = os_state_reg == OS_RUN && ctrl_reg.one_shot &&
                  ctrl_reg.start && !os_trig && tick && cnt_le1;
        os_load = os_trig | os_done;
        os_dec = os_state_reg == OS_RUN && ctrl_reg.one_shot &&
                 ctrl_reg.start && tick && !os_load;
        os_state_next = os_state_reg;
        case (os_state_reg)
            OS_IDLE: begin
                if (os_trig) begin
                    os_state_next = OS_RUN;
                end
            end
            OS_RUN: begin
                if (!ctrl_reg.start || !ctrl_reg.one_shot) begin
                    os_state_next = OS_IDLE;
                end else if (os_done) begin
                    os_state_next = OS_IDLE;
                end
            end
            default: os_state_next = OS_IDLE;
        endcase
        counting = ctrl_reg.one_shot ? os_state_reg == OS_RUN
                                     : ctrl_reg.start;
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            os_state_reg <= OS_IDLE;
        end else begin
            os_state_reg <= os_state_next;
        end
    end
    // Control register
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_reg <= CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_reg <= bus_req.wdata[CTRL_W-1:0];
            ctrl_reg.os_start <= 1'b0;
        end
    end

    // Reload register
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            reload_reg <= TIMER_RST[CNT_W-1:0];
        end else if (wr_timer) begin
            reload_reg <= bus_req.wdata[CNT_W-1:0];
        end
    end
    // Counter
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_reg <= TIMER_RST[CNT_W-1:0];
        end else if (wr_timer && !counting) begin
            cnt_reg <= bus_req.wdata[CNT_W-1:0];
        end else if (tp_step) begin
            if (tp_wrap && !ctrl_reg.free_run) begin
                cnt_reg <= reload_reg;
            end else if (up) begin
                cnt_reg <= cnt_reg + 1'b1;
            end else begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end else if (os_load) begin
            cnt_reg <= reload_reg;
        end else if (os_dec) begin
            cnt_reg <= cnt_reg - 1'b1;
        end
    end

    // Status, mask and interrupt
    always_comb begin
        stat_next = stat_reg & ~(wr_status ? bus_req.wdata[STAT_W-1:0] : '0);
        stat_next[ST_WRAP_BIT] = stat_next[ST_WRAP_BIT] | tp_wrap;
        stat_next[ST_OS_BIT] = stat_next[ST_OS_BIT] | os_done;
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            stat_reg <= STAT_RST;
        end else begin
            stat_reg <= stat_next;
        end
    end
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            mask_reg <= MASK_RST;
        end else if (wr_mask) begin
            mask_reg <= bus_req.wdata[STAT_W-1:0];
        end
    end
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(stat_next & mask_reg);
        end
    end
    // Read data
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_reg <= '0;
        end else if (bus_req.rd) begin
            case (bus_req.addr)
                TIMER_OFS: begin
                    if (ctrl_reg.one_shot) begin
                        rdata_reg <= OS_READ_VAL;
                    end else begin
                        rdata_reg <= to_data(cnt_reg);
                    end
                end
                CTRL_OFS: rdata_reg <= DATA_W'(ctrl_reg);
                STATUS_OFS: rdata_reg <= DATA_W'(stat_reg);
                MASK_OFS: rdata_reg <= DATA_W'(mask_reg);
                STATE_OFS: rdata_reg <= DATA_W'({b_s2_reg, a_s2_reg,
                                                 counting});
                default: rdata_reg <= '0;
            endcase
        end else begin
            rdata_reg <= '0;
        end
    end

    // Phase B pin drive
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pin_oe_reg <= 1'b0;
            pin_o_reg <= 1'b0;
        end else begin
            pin_oe_reg <= ctrl_reg.one_shot & ctrl_reg.pulse_out_en;
            pin_o_reg <= ctrl_reg.one_shot & ctrl_reg.pulse_out_en &
                         (os_state_next == OS_RUN);
        end
    end
    assign bus_rdata = rdata_reg;
    assign irq = irq_reg;
    assign phase_b_pulse_pin_o = pin_o_reg;
    assign phase_b_pulse_pin_oe = pin_oe_reg;

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    property p_tp_up;
        tp_step && up && !tp_wrap && !wr_timer |=>
            cnt_reg == $past(cnt_reg) + 1'b1;
    endproperty
    a_tp_up: assert property (p_tp_up) else $error("up step lost");
    property p_tp_dn;
        tp_active && !ctrl_reg.x4 && b_s2_reg && a_fall && !tp_wrap &&
        !wr_timer |=> cnt_reg == $past(cnt_reg) - 1'b1;
    endproperty
    a_tp_dn: assert property (p_tp_dn) else $error("down step lost");
    property p_x4;
        tp_active && ctrl_reg.x4 && b_chg && !a_chg && !tp_wrap &&
        !wr_timer |=> cnt_reg != $past(cnt_reg);
    endproperty
    a_x4: assert property (p_x4) else $error("x4 edge missed");
    property p_reload;
        tp_wrap && !ctrl_reg.free_run && !wr_timer |=>
            cnt_reg == $past(reload_reg);
    endproperty
    a_reload: assert property (p_reload) else $error("no reload");
    property p_free;
        tp_wrap && ctrl_reg.free_run && up && !wr_timer |=> cnt_reg == '0;
    endproperty
    a_free: assert property (p_free) else $error("free-run wrap bad");
    property p_irq_tp;
        tp_wrap && mask_reg[ST_WRAP_BIT] |=>
            stat_reg[ST_WRAP_BIT] && irq;
    endproperty
    a_irq_tp: assert property (p_irq_tp) else $error("wrap irq missing");
    property p_stop;
        !ctrl_reg.start && !wr_timer |=> $stable(cnt_reg);
    endproperty
    a_stop: assert property (p_stop) else $error("counted while stopped");
    property p_wr_run;
        wr_timer && counting && !tp_step && !os_load && !os_dec |=>
            reload_reg == $past(bus_req.wdata[CNT_W-1:0]) &&
            cnt_reg == $past(cnt_reg);
    endproperty
    a_wr_run: assert property (p_wr_run) else $error("run write hit counter");
    property p_os_done;
        os_done && !wr_timer |=> os_state_reg == OS_IDLE &&
            cnt_reg == $past(reload_reg) && stat_reg[ST_OS_BIT];
    endproperty
    a_os_done: assert property (p_os_done) else $error("one-shot end bad");
    property p_os_read;
        bus_req.rd && bus_req.addr == TIMER_OFS && ctrl_reg.one_shot |=>
            bus_rdata == OS_READ_VAL;
    endproperty
    a_os_read: assert property (p_os_read) else $error("one-shot read bad");

    c_overflow: cover property (tp_wrap && up);
    c_underflow: cover property (tp_wrap && !up);
    c_os_done: cover property (os_done);
    c_os_retrig: cover property (os_state_reg == OS_RUN && os_trig);

endmodule // tpc_timer

`default_nettype wire

// ---- rtl/tpc_pkg.sv ----
// Package: constants and types for the two-phase counter and one-shot timer
package tpc_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 8;
    localparam int STAT_W = 2;
    localparam int PRESC_W = 5;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] TIMER_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] MASK_OFS = 8'h0c;
    localparam logic [ADDR_W-1:0] STATE_OFS = 8'h10;

    // Status bit positions
    localparam int ST_WRAP_BIT = 0;
    localparam int ST_OS_BIT = 1;

    // Reset values
    localparam logic [DATA_W-1:0] TIMER_RST = 16'h0000;
    localparam logic [STAT_W-1:0] MASK_RST = 2'h0;
    localparam logic [STAT_W-1:0] STAT_RST = 2'h0;

    // Timer read value in one-shot mode
    localparam logic [DATA_W-1:0] OS_READ_VAL = 16'hffff;

    // Prescaler terminal counts
    localparam logic [2:0] DIV8_LAST = 3'h7;
    localparam logic [PRESC_W-1:0] DIV32_LAST = 5'h1f;

    typedef enum logic [1:0] {
        CSEL_DIV1,
        CSEL_DIV8,
        CSEL_DIV32,
        CSEL_SUB32
    } tpc_csel_t;

    typedef enum logic [1:0] {
        TSEL_SOFT,
        TSEL_PIN,
        TSEL_TIMER,
        TSEL_NONE
    } tpc_tsel_t;

    // Control register, bit 0 upward: start, os_start, one_shot, x4,
    // free_run, csel[1:0], tsel[1:0], pulse_out_en
    typedef struct packed {
        logic pulse_out_en;
        tpc_tsel_t tsel;
        tpc_csel_t csel;
        logic free_run;
        logic x4;
        logic one_shot;
        logic os_start;
        logic start;
    } tpc_ctrl_t;

    localparam int CTRL_W = $bits(tpc_ctrl_t);
    localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } tpc_bus_req_t;
endpackage

// ---- test/tpc_enc_model.sv ----
// Quadrature encoder and trigger source model
`timescale 1ns/100ps
`default_nettype none

module tpc_enc_model (
    input wire logic mclk,
    output logic phase_a = 1'b0,
    output logic phase_b = 1'b0,
    output logic b_drive_en = 1'b1
);
    logic [1:0] pos_reg = 2'h0;

    // Gray order 00,01,11,10 on (a,b); each level held 5 cycles
    task automatic quarter(input logic fwd);
        pos_reg = fwd ? pos_reg + 2'h1 : pos_reg - 2'h1;
        @(posedge mclk);
        phase_a <= pos_reg[1];
        phase_b <= pos_reg[1] ^ pos_reg[0];
        repeat (4) @(posedge mclk);
    endtask

    // Whole encoder periods
    task automatic cycle(input logic fwd, input int n);
        repeat (4 * n) quarter(fwd);
    endtask

    // Rising edge on pin A as one-shot trigger
    task automatic trig;
        @(posedge mclk);
        phase_a <= 1'b0;
        repeat (4) @(posedge mclk);
        phase_a <= 1'b1;
        repeat (4) @(posedge mclk);
        phase_a <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask

    // Let go of pin B so the block may drive it
    task automatic release_b;
        @(posedge mclk);
        b_drive_en <= 1'b0;
    endtask
endmodule // tpc_enc_model
`default_nettype wire

// ---- test/two_phase_counter_and_one_shot_timer_tb.sv ----
// Testbench for the two-phase counter and one-shot timer
`timescale 1ns/100ps
`default_nettype none

module two_phase_counter_and_one_shot_timer_tb;
    import tpc_pkg::*;
    logic mclk = 1'b0;
    logic sub_clk = 1'b0;
    logic reset_n, other_timer_ovf, irq;
    tpc_bus_req_t bus_req;
    logic [DATA_W-1:0] bus_rdata;
    logic pin_b_o, pin_b_oe, enc_a, enc_b, enc_b_en, pin_b_wire;
    int bad_count, samples_checked;
    int cycles = 0;

    assign pin_b_wire = pin_b_oe ? pin_b_o : (enc_b_en ? enc_b : ~pin_b_o);

    tpc_timer tpc_timer_inst (.mclk(mclk), .reset_n(reset_n),
        .bus_req(bus_req), .bus_rdata(bus_rdata),
        .phase_a_trigger_pin(enc_a), .phase_b_pulse_pin_i(pin_b_wire),
        .phase_b_pulse_pin_o(pin_b_o), .phase_b_pulse_pin_oe(pin_b_oe),
        .other_timer_ovf(other_timer_ovf), .sub_clk(sub_clk), .irq(irq));
    tpc_enc_model tpc_enc_model_inst (.mclk(mclk), .phase_a(enc_a),
        .phase_b(enc_b), .b_drive_en(enc_b_en));

    always #2 mclk = ~mclk;
    always #20 sub_clk = ~sub_clk;

    always @(posedge mclk) begin
        cycles++;
    end

    task automatic summarize;
        if (bad_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] exp,
                       input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", name, exp, got);
            bad_count++;
        end
    endtask

    task automatic bus_wr(input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] d);
        @(posedge mclk);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge mclk);
        bus_req.wr <= 1'b0;
        #1;
    endtask

    task automatic bus_rd(input logic [ADDR_W-1:0] a,
                          output logic [DATA_W-1:0] d);
        @(posedge mclk);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge mclk);
        bus_req.rd <= 1'b0;
        #1 d = bus_rdata;
    endtask

    task automatic chk_rd(input string name, input logic [ADDR_W-1:0] a,
                          input logic [15:0] exp);
        logic [DATA_W-1:0] d;
        bus_rd(a, d);
        chk(name, exp, d);
    endtask

    task automatic chk_run(input logic exp);
        logic [DATA_W-1:0] d;
        bus_rd(STATE_OFS, d);
        chk("counting", {15'h0000, exp}, {15'h0000, d[0]});
    endtask

    task automatic chk_irq(input logic exp);
        chk("irq", {15'h0000, exp}, {15'h0000, irq});
    endtask

    task automatic t_reset;
        chk_irq(1'b0);
        chk_rd("timer", TIMER_OFS, TIMER_RST);
        chk_rd("ctrl", CTRL_OFS, {6'h00, CTRL_RST});
        chk_rd("status", STATUS_OFS, {14'h0000, STAT_RST});
        chk_rd("mask", MASK_OFS, {14'h0000, MASK_RST});
        chk_rd("unmapped", 8'h14, 16'h0000);
    endtask

    task automatic t_count;
        bus_wr(TIMER_OFS, 16'h0010);
        tpc_enc_model_inst.cycle(1'b1, 1);
        chk_rd("timer stopped", TIMER_OFS, 16'h0010);
        bus_wr(CTRL_OFS, 16'h0001);
        tpc_enc_model_inst.cycle(1'b1, 2);
        chk_rd("normal up", TIMER_OFS, 16'h0012);
        tpc_enc_model_inst.cycle(1'b0, 3);
        chk_rd("normal down", TIMER_OFS, 16'h000f);
        bus_wr(CTRL_OFS, 16'h0009);
        tpc_enc_model_inst.cycle(1'b1, 1);
        chk_rd("x4 up", TIMER_OFS, 16'h0013);
        tpc_enc_model_inst.cycle(1'b0, 2);
        chk_rd("x4 down", TIMER_OFS, 16'h000b);
    endtask

    task automatic t_wrap;
        bus_wr(CTRL_OFS, 16'h0000);
        bus_wr(MASK_OFS, 16'h0001);
        bus_wr(TIMER_OFS, 16'hfffe);
        bus_wr(CTRL_OFS, 16'h0001);
        bus_wr(TIMER_OFS, 16'hfff0);
        chk_rd("reload only", TIMER_OFS, 16'hfffe);
        tpc_enc_model_inst.cycle(1'b1, 1);
        chk_rd("before ovf", TIMER_OFS, 16'hffff);
        chk_irq(1'b0);
        tpc_enc_model_inst.cycle(1'b1, 1);
        chk_rd("after ovf", TIMER_OFS, 16'hfff0);
        chk_irq(1'b1);
        chk_rd("wrap flag", STATUS_OFS, 16'h0001);
        bus_wr(STATUS_OFS, 16'h0001);
        chk_irq(1'b0);
        bus_wr(CTRL_OFS, 16'h0000);
        bus_wr(TIMER_OFS, 16'h0001);
        bus_wr(CTRL_OFS, 16'h0001);
        tpc_enc_model_inst.cycle(1'b0, 1);
        chk_rd("before unf", TIMER_OFS, 16'h0000);
        tpc_enc_model_inst.cycle(1'b0, 1);
        chk_rd("after unf", TIMER_OFS, 16'h0001);
        chk_irq(1'b1);
        bus_wr(STATUS_OFS, 16'h0001);
        bus_wr(CTRL_OFS, 16'h0000);
        bus_wr(TIMER_OFS, 16'hffff);
        bus_wr(CTRL_OFS, 16'h0011);
        tpc_enc_model_inst.cycle(1'b1, 1);
        chk_rd("free run", TIMER_OFS, 16'h0000);
        bus_wr(STATUS_OFS, 16'h0001);
        bus_wr(CTRL_OFS, 16'h0000);
    endtask

    task automatic t_oneshot;
        tpc_enc_model_inst.release_b();
        bus_wr(MASK_OFS, 16'h0002);
        bus_wr(TIMER_OFS, 16'h0008);
        bus_wr(CTRL_OFS, 16'h0205);
        bus_wr(CTRL_OFS, 16'h0207);
        chk("pin oe", 16'h0001, {15'h0000, pin_b_oe});
        chk("pin high", 16'h0001, {15'h0000, pin_b_wire});
        chk_rd("os read", TIMER_OFS, OS_READ_VAL);
        bus_wr(CTRL_OFS, 16'h0207);
        repeat (3) @(posedge mclk);
        chk_run(1'b1);
        repeat (10) @(posedge mclk);
        chk_run(1'b0);
        chk_rd("done flag", STATUS_OFS, 16'h0002);
        chk_irq(1'b1);
        chk("pin low", 16'h0000, {15'h0000, pin_b_wire});
        bus_wr(STATUS_OFS, 16'h0002);
        chk_irq(1'b0);
    endtask

    task automatic t_triggers;
        bus_wr(CTRL_OFS, 16'h0000);
        bus_wr(TIMER_OFS, 16'h0020);
        bus_wr(CTRL_OFS, 16'h0085);
        tpc_enc_model_inst.trig();
        chk_run(1'b1);
        bus_wr(CTRL_OFS, 16'h0084);
        chk_run(1'b0);
        bus_wr(CTRL_OFS, 16'h0105);
        @(posedge mclk);
        other_timer_ovf <= 1'b1;
        @(posedge mclk);
        other_timer_ovf <= 1'b0;
        repeat (2) @(posedge mclk);
        chk_run(1'b1);
        bus_wr(CTRL_OFS, 16'h0000);
        bus_wr(CTRL_OFS, 16'h0185);
        tpc_enc_model_inst.trig();
        chk_run(1'b0);
        bus_wr(CTRL_OFS, 16'h0000);
    endtask

    task automatic t_sources;
        int per;
        for (int c = 0; c < 4; c++) begin
            per = (c == 0) ? 1 : (c == 1) ? 8 : (c == 2) ? 32 : 320;
            bus_wr(TIMER_OFS, 16'h0002);
            bus_wr(CTRL_OFS, {9'h000, 2'(c), 5'h05});
            bus_wr(CTRL_OFS, {9'h000, 2'(c), 5'h07});
            repeat (per / 2) @(posedge mclk);
            chk_run(1'b1);
            repeat (2 * per + 8) @(posedge mclk);
            chk_run(1'b0);
            chk_irq(1'b1);
            bus_wr(STATUS_OFS, 16'h0002);
            bus_wr(CTRL_OFS, 16'h0000);
            chk_rd("reloaded", TIMER_OFS, 16'h0002);
        end
    endtask

    initial begin
        reset_n = 1'b0;
        other_timer_ovf = 1'b0;
        bus_req = '0;
        bad_count = 0;
        samples_checked = 0;
        repeat (5) @(posedge mclk);
        reset_n <= 1'b1;
        fork
            begin
                t_reset();
                t_count();
                t_wrap();
                t_oneshot();
                t_triggers();
                t_sources();
            end
            begin
                wait (cycles >= 20000);
                bad_count++;
            end
        join_any
        summarize();
    end
endmodule // two_phase_counter_and_one_shot_timer_tb
`default_nettype wire
